// >>> hdl/ebct_clock_unit.sv
/*
 Prescaler, clock source select and pin synchronisers for the timer.
 Assumes pins are asynchronous to sys_clk; selection comes from core ports.
*/
`timescale 1ns/100ps
`include "ebct_params.svh"
module ebct_clock_unit
    import ebct_pkg::*;
(
    input wire logic sys_clk, // System clock
    input wire logic sys_rst, // Synchronous reset
    input wire logic clk_en, // Freezes state when low
    input wire logic [`EBCT_SEL_W-1:0] clock_sel, // {internal_clock_sel, clock_sel_2..0}
    input wire logic ext_clock_pin, // External count clock
    input wire logic external_clear_pin, // Clear pin
    input wire logic trigger_input_pin, // Trigger pin
    ebct_tick_if.src tick // Ticks to the core
);

    logic [`EBCT_PRE_W-1:0] pre_q;
    logic [2:0] sync1_q, sync2_q, prev_q;
    logic src_q;
    logic src_d;

    ///////////////////////////////////////////////////////////////////////////
    // Free-running prescaler
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pre_q <= `EBCT_PRE_ZERO;
        end else if (clk_en) begin
            pre_q <= pre_q + `EBCT_PRE_ONE;
        end
    end

    // Two-stage synchronisers, then a history stage for edge detect
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            prev_q <= 3'h0;
        end else if (clk_en) begin
            sync1_q <= {trigger_input_pin, external_clear_pin, ext_clock_pin};
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // Selected source level; internal taps counted on falling edges
    always_comb begin
        case (clock_sel)
            `EBCT_SEL_INT_0: src_d = pre_q[`EBCT_TAP_0];
            `EBCT_SEL_INT_1: src_d = pre_q[`EBCT_TAP_1];
            `EBCT_SEL_INT_2: src_d = pre_q[`EBCT_TAP_2];
            `EBCT_SEL_INT_3: src_d = pre_q[`EBCT_TAP_3];
            `EBCT_SEL_INT_4: src_d = pre_q[`EBCT_TAP_4];
            `EBCT_SEL_INT_5: src_d = pre_q[`EBCT_TAP_5];
            `EBCT_SEL_EXT_RISE: src_d = ~sync2_q[0]; // Pin rise seen as a fall
            `EBCT_SEL_EXT_FALL, `EBCT_SEL_EXT_BOTH: src_d = sync2_q[0];
            default: src_d = 1'b0;
        endcase
    end

    // Source history; a switch seen as a falling edge counts once
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            src_q <= 1'b0;
        end else if (clk_en) begin
            src_q <= src_d;
        end
    end

    // Ticks: falling edge of chosen level, or any edge in both-edge mode
    assign tick.count_tick = (clock_sel == `EBCT_SEL_EXT_BOTH) ? (src_q != src_d)
                           : (src_q & ~src_d);
    assign tick.clear_rise = sync2_q[1] & ~prev_q[1];
    assign tick.trig_rise = sync2_q[2] & ~prev_q[2];
    assign tick.trig_fall = ~sync2_q[2] & prev_q[2];
endmodule

// >>> hdl/ebct_params.svh
/*
 Constants of the eight-bit compare timer: encodings, widths, reset values.
 Assumes inclusion by bare name from the package and modules.
*/
`ifndef EBCT_PARAMS_SVH
`define EBCT_PARAMS_SVH

`define EBCT_CNT_W 8
`define EBCT_CNT_ZERO 8'h00
`define EBCT_CNT_MAX 8'hFF
`define EBCT_CNT_ONE 8'h01
`define EBCT_OS_NONE 2'b00
`define EBCT_OS_ZERO 2'b01
`define EBCT_OS_ONE 2'b10
`define EBCT_OS_TOG 2'b11
`define EBCT_CLR_NONE 2'b00
`define EBCT_CLR_A 2'b01
`define EBCT_CLR_B 2'b10
`define EBCT_CLR_PIN 2'b11
`define EBCT_TRG_OFF 2'b00
`define EBCT_TRG_RISE 2'b01
`define EBCT_TRG_FALL 2'b10
`define EBCT_TRG_BOTH 2'b11
`define EBCT_PRE_W 13
`define EBCT_PRE_ZERO 13'h0000
`define EBCT_PRE_ONE 13'h0001
`define EBCT_SEL_W 4
`define EBCT_SEL_STOP 4'h0
`define EBCT_SEL_INT_0 4'h1
`define EBCT_SEL_INT_1 4'h2
`define EBCT_SEL_INT_2 4'h3
`define EBCT_SEL_INT_3 4'h4
`define EBCT_SEL_INT_4 4'h9
`define EBCT_SEL_INT_5 4'hA
`define EBCT_SEL_EXT_RISE 4'h5
`define EBCT_SEL_EXT_FALL 4'h6
`define EBCT_SEL_EXT_BOTH 4'h7
`define EBCT_TAP_0 4'd1
`define EBCT_TAP_1 4'd2
`define EBCT_TAP_2 4'd4
`define EBCT_TAP_3 4'd5
`define EBCT_TAP_4 4'd6
`define EBCT_TAP_5 4'd12

`endif

// >>> hdl/ebct_pkg.sv
/*
 Types of the eight-bit compare timer.
 Assumes ebct_params.svh is on the include path.
*/
package ebct_pkg;
`include "ebct_params.svh"

    typedef logic [`EBCT_CNT_W-1:0] ebct_cnt_type;

    // Run state of the counter in trigger mode
    typedef enum logic [1:0] {
        EBCT_RUN = 2'b01,
        EBCT_HALT = 2'b10
    } ebct_run_type;
endpackage

// >>> hdl/ebct_tick_if.sv
/*
 Interface carrying count ticks and pin edges from the clock unit to the core.
 Assumes one clock domain.
*/
`timescale 1ns/100ps
interface ebct_tick_if;
    logic count_tick; // One-cycle increment pulse
    logic clear_rise; // Rising edge seen on clear pin
    logic trig_rise; // Rising edge on trigger pin
    logic trig_fall; // Falling edge on trigger pin

    modport src (output count_tick, output clear_rise, output trig_rise, output trig_fall);
    modport dst (input count_tick, input clear_rise, input trig_rise, input trig_fall);
endinterface

// >>> hdl/ebct_top.sv
/*
 Eight-bit up-counter timer with two compare constants, flags, interrupt
 requests, compare output pin, clear sources and trigger start.
 Assumes a processor-side write strobe marks the final state of a write cycle,
 and that pins are asynchronous to sys_clk.
*/
`timescale 1ns/100ps
`include "ebct_params.svh"

// Operation
// - Count up on each selected clock edge
// - Overflow from max to zero sets flag
// - Overflow interrupt when flag and enable set
// - Compare counter against A and B continuously
// - Match pulse in last equal state
// - Match interrupts from flag and enable
// - Match drives pin by select field
// - Select: none, zero, one, toggle
// - Output pin low after reset
// - Clear select 01/10 clears on match
// - Clear select 11 clears on pin rise
// - Trigger mode halts after clear, edge restarts
// - Trigger edge: off, rise, fall, both
// - Clear beats counter write
// - Counter write beats increment
// - Constant write suppresses match pulse
// - Toggle beats one beats zero
// - Internal count on divided falling edges
// - Source switch may add one count
module ebct_top
    import ebct_pkg::*;
(
    input wire logic sys_clk, // System clock, 25 MHz
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic clk_en, // Clock enable
    input wire logic clock_sel_2, // Clock select bit 2
    input wire logic clock_sel_1, // Clock select bit 1
    input wire logic clock_sel_0, // Clock select bit 0
    input wire logic internal_clock_sel, // Internal clock select
    input wire logic clear_sel_hi, // Clear select high bit
    input wire logic clear_sel_lo, // Clear select low bit
    input wire logic out_sel_a_hi, // Output select A high
    input wire logic out_sel_a_lo, // Output select A low
    input wire logic out_sel_b_hi, // Output select B high
    input wire logic out_sel_b_lo, // Output select B low
    input wire logic trigger_enable, // Trigger mode enable
    input wire logic trigger_edge_hi, // Trigger edge high bit
    input wire logic trigger_edge_lo, // Trigger edge low bit
    input wire logic overflow_irq_enable, // Overflow interrupt enable
    input wire logic match_irq_enable_a, // Match A interrupt enable
    input wire logic match_irq_enable_b, // Match B interrupt enable
    input wire logic count_wr, // Counter write, final state
    input wire logic [7:0] count_wdata, // Counter write data
    input wire logic const_a_wr, // Compare A write, final state
    input wire logic [7:0] const_a_wdata, // Compare A write data
    input wire logic const_b_wr, // Compare B write, final state
    input wire logic [7:0] const_b_wdata, // Compare B write data
    input wire logic flag_clr_ovf, // Clear overflow flag
    input wire logic flag_clr_a, // Clear match flag A
    input wire logic flag_clr_b, // Clear match flag B
    input wire logic ext_clock_pin, // External count clock pin
    input wire logic external_clear_pin, // External clear pin
    input wire logic trigger_input_pin, // Trigger input pin
    output logic [7:0] count_value, // Counter
    output logic [7:0] compare_const_a, // Compare constant A
    output logic [7:0] compare_const_b, // Compare constant B
    output logic overflow_flag, // Overflow flag
    output logic match_flag_a, // Match flag A
    output logic match_flag_b, // Match flag B
    output logic overflow_irq, // Overflow interrupt request
    output logic match_irq_a, // Match A interrupt request
    output logic match_irq_b, // Match B interrupt request
    output logic compare_output_pin, // Compare output pin
    output logic counting // Counter running (not halted)
);

    ebct_tick_if tick ();

    ebct_cnt_type count_q, const_a_q, const_b_q;
    logic ovf_q, match_flag_a_q, match_flag_b_q, pin_q;
    logic ovf_irq_q, irq_a_q, irq_b_q;
    ebct_run_type run_q;
    logic [1:0] clear_sel, trig_sel, os_a, os_b;
    logic match_a, match_b, clear_ev, inc, trig_ev, overflow;

    ///////////////////////////////////////////////////////////////////////////
    // Clock source and pin edges

    ebct_clock_unit u_clock (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .clock_sel({internal_clock_sel, clock_sel_2, clock_sel_1, clock_sel_0}),
        .ext_clock_pin(ext_clock_pin),
        .external_clear_pin(external_clear_pin),
        .trigger_input_pin(trigger_input_pin),
        .tick(tick)
    );

    ///////////////////////////////////////////////////////////////////////////
    // Output action applied by one match
    function automatic logic apply_os(input logic [1:0] sel, input logic cur);
        case (sel)
            `EBCT_OS_ZERO: apply_os = 1'b0;
            `EBCT_OS_ONE: apply_os = 1'b1;
            `EBCT_OS_TOG: apply_os = ~cur;
            default: apply_os = cur;
        endcase
    endfunction

    // Field assembly
    assign clear_sel = {clear_sel_hi, clear_sel_lo};
    assign trig_sel = {trigger_edge_hi, trigger_edge_lo};
    assign os_a = {out_sel_a_hi, out_sel_a_lo};
    assign os_b = {out_sel_b_hi, out_sel_b_lo};

    // Match pulse: equal now and stepping away (last equal state), one pulse only
    assign match_a = (count_q == const_a_q) & inc & ~const_a_wr;
    assign match_b = (count_q == const_b_q) & inc & ~const_b_wr;

    // Clear sources
    assign clear_ev = ((clear_sel == `EBCT_CLR_A) & match_a)
                    | ((clear_sel == `EBCT_CLR_B) & match_b)
                    | ((clear_sel == `EBCT_CLR_PIN) & tick.clear_rise);

    // Trigger edge select
    assign trig_ev = ((trig_sel == `EBCT_TRG_RISE) & tick.trig_rise)
                   | ((trig_sel == `EBCT_TRG_FALL) & tick.trig_fall)
                   | ((trig_sel == `EBCT_TRG_BOTH) & (tick.trig_rise | tick.trig_fall));

    // Increment only while running
    assign inc = tick.count_tick & (run_q == EBCT_RUN);
    assign overflow = inc & (count_q == `EBCT_CNT_MAX) & ~count_wr & ~clear_ev;

    ///////////////////////////////////////////////////////////////////////////
    // Counter with clear, write and increment priorities
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            count_q <= `EBCT_CNT_ZERO;
        end else if (clk_en) begin
            if (clear_ev) begin
                count_q <= `EBCT_CNT_ZERO;
            end else if (count_wr) begin
                count_q <= count_wdata;
            end else if (inc) begin
                count_q <= count_q + `EBCT_CNT_ONE;
            end
        end
    end

    // Compare constants
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            const_a_q <= `EBCT_CNT_MAX;
            const_b_q <= `EBCT_CNT_MAX;
        end else if (clk_en) begin
            if (const_a_wr) begin
                const_a_q <= const_a_wdata;
            end
            if (const_b_wr) begin
                const_b_q <= const_b_wdata;
            end
        end
    end

    // Trigger run state: halt after clear, restart on edge
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            run_q <= EBCT_RUN;
        end else if (clk_en) begin
            case (run_q)
                EBCT_RUN: begin
                    if (trigger_enable & clear_ev) begin
                        run_q <= EBCT_HALT;
                    end
                end
                EBCT_HALT: begin
                    if (trig_ev | ~trigger_enable) begin
                        run_q <= EBCT_RUN;
                    end
                end
                default: begin
                    run_q <= EBCT_RUN;
                end
            endcase
        end
    end

    // Sticky flags; set wins over clearing write
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ovf_q <= 1'b0;
            match_flag_a_q <= 1'b0;
            match_flag_b_q <= 1'b0;
        end else if (clk_en) begin
            ovf_q <= overflow | (ovf_q & ~flag_clr_ovf);
            match_flag_a_q <= match_a | (match_flag_a_q & ~flag_clr_a);
            match_flag_b_q <= match_b | (match_flag_b_q & ~flag_clr_b);
        end
    end

    // Interrupt requests registered from flags and enables
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ovf_irq_q <= 1'b0;
            irq_a_q <= 1'b0;
            irq_b_q <= 1'b0;
        end else if (clk_en) begin
            ovf_irq_q <= ovf_q & overflow_irq_enable;
            irq_a_q <= match_flag_a_q & match_irq_enable_a;
            irq_b_q <= match_flag_b_q & match_irq_enable_b;
        end
    end

    // Compare output pin; simultaneous matches resolved toggle > 1 > 0
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pin_q <= 1'b0;
        end else if (clk_en) begin
            if (match_a & match_b) begin
                if ((os_a == `EBCT_OS_TOG) | (os_b == `EBCT_OS_TOG)) begin
                    pin_q <= ~pin_q;
                end else if ((os_a == `EBCT_OS_ONE) | (os_b == `EBCT_OS_ONE)) begin
                    pin_q <= 1'b1;
                end else if ((os_a == `EBCT_OS_ZERO) | (os_b == `EBCT_OS_ZERO)) begin
                    pin_q <= 1'b0;
                end
            end else if (match_a) begin
                pin_q <= apply_os(os_a, pin_q);
            end else if (match_b) begin
                pin_q <= apply_os(os_b, pin_q);
            end
        end
    end

    ///////////////////////////////////////////////////////////////////////////
    // Outputs straight from flip-flops
    assign count_value = count_q;
    assign compare_const_a = const_a_q;
    assign compare_const_b = const_b_q;
    assign overflow_flag = ovf_q;
    assign match_flag_a = match_flag_a_q;
    assign match_flag_b = match_flag_b_q;
    assign overflow_irq = ovf_irq_q;
    assign match_irq_a = irq_a_q;
    assign match_irq_b = irq_b_q;
    assign compare_output_pin = pin_q;
    assign counting = run_q[0]; // One-hot run bit
endmodule

// >>> testbench/ebct_pin_model.sv
/*
 Model of the pins outside the timer: external count clock, clear and trigger.
 Assumes the bench calls its tasks; every task returns on a falling edge.
*/
`timescale 1ns/100ps
module ebct_pin_model (
    input wire logic sys_clk, // System clock
    output logic ext_clock_pin = 1'b0, // External count clock
    output logic external_clear_pin = 1'b0, // Clear pin
    output logic trigger_input_pin = 1'b0 // Trigger pin
);
    ////////////////////////////////////////////////////////////////////////////////
    // Count clock pulses, three cycles high and four low between pulses, idle low
    task automatic ext_pulses(input int n);
        repeat (n) begin
            @(negedge sys_clk);
            ext_clock_pin = 1'b1;
            repeat (3) @(negedge sys_clk);
            ext_clock_pin = 1'b0;
            repeat (3) @(negedge sys_clk);
        end
    endtask
    // Clear pulse held three cycles, well over the minimum width
    task automatic clear_pulse();
        @(negedge sys_clk);
        external_clear_pin = 1'b1;
        repeat (3) @(negedge sys_clk);
        external_clear_pin = 1'b0;
        repeat (4) @(negedge sys_clk);
    endtask
    // One edge on the trigger pin, then time for the synchroniser
    task automatic trig_toggle();
        @(negedge sys_clk);
        trigger_input_pin = ~trigger_input_pin;
        repeat (5) @(negedge sys_clk);
    endtask
endmodule

// >>> testbench/ebct_top_assertions.sv
/*
 Concurrent checks on the ports of the compare timer top.
 Assumes clk_en stays high and reset is held for several cycles.
*/
`timescale 1ns/100ps
module ebct_top_assertions (
    input wire logic sys_clk, // Clock
    input wire logic sys_rst, // Reset
    input wire logic clk_en, // Enable
    input wire logic clear_sel_hi, // Clear select high
    input wire logic clear_sel_lo, // Clear select low
    input wire logic out_sel_a_hi, // Output select A high
    input wire logic out_sel_a_lo, // Output select A low
    input wire logic out_sel_b_hi, // Output select B high
    input wire logic out_sel_b_lo, // Output select B low
    input wire logic overflow_irq_enable, // Overflow enable
    input wire logic match_irq_enable_a, // Match A enable
    input wire logic match_irq_enable_b, // Match B enable
    input wire logic count_wr, // Counter write
    input wire logic const_a_wr, // Constant A write
    input wire logic flag_clr_ovf, // Overflow flag clear
    input wire logic [7:0] count_wdata, // Counter data
    input wire logic [7:0] const_a_wdata, // Constant A data
    input wire logic [7:0] count_value, // Counter
    input wire logic [7:0] compare_const_a, // Constant A
    input wire logic overflow_flag, // Overflow flag
    input wire logic match_flag_a, // Match flag A
    input wire logic match_flag_b, // Match flag B
    input wire logic overflow_irq, // Overflow request
    input wire logic match_irq_a, // Match A request
    input wire logic match_irq_b, // Match B request
    input wire logic compare_output_pin, // Compare pin
    input wire logic counting // Run state
);
    wire [1:0] clr = {clear_sel_hi, clear_sel_lo};
    wire [3:0] osel = {out_sel_a_hi, out_sel_a_lo, out_sel_b_hi, out_sel_b_lo};
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////////////
    // Reset leaves counter, constant and pin at their idle values
    a_reset_idle: assert property ($past(sys_rst) |-> !compare_output_pin &&
        count_value == 8'h00 && compare_const_a == 8'hFF) else $error("reset state wrong");
    // Requests follow flag and enable by one cycle
    a_ovf_irq_path: assert property ($past(clk_en) |->
        overflow_irq == $past(overflow_flag && overflow_irq_enable)) else $error("ovf irq");
    a_irq_a_path: assert property ($past(clk_en) |->
        match_irq_a == $past(match_flag_a && match_irq_enable_a)) else $error("irq a");
    a_irq_b_path: assert property ($past(clk_en) |->
        match_irq_b == $past(match_flag_b && match_irq_enable_b)) else $error("irq b");
    // Overflow flag drops only on a clear strobe
    a_flag_held: assert property ($fell(overflow_flag) |-> $past(flag_clr_ovf))
        else $error("overflow flag dropped alone");
    // Roll over from top to zero raises the flag
    a_ovf_sets: assert property ($past(count_value) == 8'hFF && count_value == 8'h00 &&
        clr == 2'b00 && !$past(count_wr) |-> ##[0:1] overflow_flag) else $error("no overflow");
    // Without write or clear the counter only steps by one
    a_count_step: assert property (!$past(count_wr) && $past(clr) == 2'b00 &&
        clr == 2'b00 |->
        count_value == $past(count_value) || count_value == $past(count_value) + 8'h01)
        else $error("counter jumped");
    // A counter write is loaded even against an increment
    a_wr_loads: assert property (count_wr && clk_en && clr == 2'b00 |=>
        count_value == $past(count_wdata)) else $error("counter write lost");
    a_const_loads: assert property (const_a_wr && clk_en |=>
        compare_const_a == $past(const_a_wdata)) else $error("constant write lost");
    // No output action selected keeps the pin still
    a_pin_quiet: assert property ($past(osel, 2) == 4'h0 && $past(osel) == 4'h0 &&
        osel == 4'h0 |-> $stable(compare_output_pin)) else $error("pin moved");
    // Halted counter does not move
    a_halt_frozen: assert property (!$past(counting) && !counting && !$past(count_wr) |->
        $stable(count_value)) else $error("halted counter moved");
endmodule

bind ebct_top ebct_top_assertions u_chk (.sys_clk, .sys_rst, .clk_en, .clear_sel_hi,
    .clear_sel_lo, .out_sel_a_hi, .out_sel_a_lo, .out_sel_b_hi, .out_sel_b_lo,
    .overflow_irq_enable, .match_irq_enable_a, .match_irq_enable_b, .count_wr, .const_a_wr,
    .flag_clr_ovf, .count_wdata, .const_a_wdata, .count_value, .compare_const_a,
    .overflow_flag, .match_flag_a, .match_flag_b, .overflow_irq, .match_irq_a, .match_irq_b,
    .compare_output_pin, .counting);

// >>> testbench/tb.sv
/*
 Self-checking bench of the compare timer, counting from the external clock pin.
 Assumes the pin model and the bound checker.
*/
`timescale 1ns/100ps
module tb;
    import ebct_pkg::*;
    logic sys_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, trg_en = 1'b0;
    logic [3:0] csel = 4'h5;
    logic [1:0] clr_sel = 2'b00, os_a = 2'b00, os_b = 2'b00, trg_edge = 2'b00;
    logic ovf_ie = 1'b1, ie_a = 1'b1, ie_b = 1'b1, cnt_wr = 1'b0, a_wr = 1'b0, b_wr = 1'b0;
    logic [2:0] fclr = 3'b000;
    logic [7:0] wdata = 8'h00, count_value, compare_const_a, compare_const_b;
    logic overflow_flag, match_flag_a, match_flag_b, overflow_irq, match_irq_a, match_irq_b;
    logic compare_output_pin, counting, ext_pin, clr_pin, trg_pin;
    int mismatches = 0, n_checks = 0, cycles = 0;
    logic [4:0] tbl [8] = '{5'b10001, 5'b01000, 5'b11001, 5'b00001, 5'b11000, 5'b01111,
        5'b01101, 5'b11100};
    logic [1:0] edges [4] = '{2'b01, 2'b10, 2'b11, 2'b00};

    ebct_top DUT (.sys_clk, .sys_rst, .clk_en, .clock_sel_2(csel[2]), .clock_sel_1(csel[1]),
        .clock_sel_0(csel[0]), .internal_clock_sel(csel[3]), .clear_sel_hi(clr_sel[1]),
        .clear_sel_lo(clr_sel[0]), .out_sel_a_hi(os_a[1]), .out_sel_a_lo(os_a[0]),
        .out_sel_b_hi(os_b[1]), .out_sel_b_lo(os_b[0]), .trigger_enable(trg_en),
        .trigger_edge_hi(trg_edge[1]), .trigger_edge_lo(trg_edge[0]),
        .overflow_irq_enable(ovf_ie), .match_irq_enable_a(ie_a), .match_irq_enable_b(ie_b),
        .count_wr(cnt_wr), .count_wdata(wdata), .const_a_wr(a_wr), .const_a_wdata(wdata),
        .const_b_wr(b_wr), .const_b_wdata(wdata), .flag_clr_ovf(fclr[2]),
        .flag_clr_a(fclr[1]), .flag_clr_b(fclr[0]), .ext_clock_pin(ext_pin),
        .external_clear_pin(clr_pin), .trigger_input_pin(trg_pin), .count_value,
        .compare_const_a, .compare_const_b, .overflow_flag, .match_flag_a, .match_flag_b,
        .overflow_irq, .match_irq_a, .match_irq_b, .compare_output_pin, .counting);
    ebct_pin_model pins (.sys_clk, .ext_clock_pin(ext_pin), .external_clear_pin(clr_pin),
        .trigger_input_pin(trg_pin));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            give_verdict();
        end
    end
    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One-cycle write strobe: 0 counter, 1 constant A, 2 constant B
    task automatic wr(input int which, input logic [7:0] d);
        @(negedge sys_clk);
        wdata = d;
        {cnt_wr, a_wr, b_wr} = {which == 0, which == 1, which == 2};
        @(negedge sys_clk);
        {cnt_wr, a_wr, b_wr} = 3'b000;
    endtask
    task automatic clr_flags();
        @(negedge sys_clk);
        fclr = 3'b111;
        @(negedge sys_clk);
        fclr = 3'b000;
        @(negedge sys_clk);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (20) @(negedge sys_clk);
        sys_rst = 1'b0;
        check(count_value, 8'h00);
        check(compare_const_b, 8'hFF);
        check(8'(compare_output_pin), 8'h00);
        check(8'(counting), 8'h01);
        $display("test reset done");
        pins.ext_pulses(5);
        check(count_value, 8'h05);
        wr(0, 8'hFE);
        pins.ext_pulses(2);
        check(count_value, 8'h00);
        check(8'(overflow_flag), 8'h01);
        check(8'(overflow_irq), 8'h01);
        clr_flags();
        check(8'(overflow_flag), 8'h00);
        check(8'(overflow_irq), 8'h00);
        $display("test count and overflow done");
        wr(1, 8'h01);
        wr(2, 8'h01);
        clr_sel = 2'b01;
        foreach (tbl[i]) begin
            {os_a, os_b} = tbl[i][4:1];
            pins.ext_pulses(2);
            check(8'(compare_output_pin), 8'(tbl[i][0]));
            check(count_value, 8'h00);
        end
        check(8'(match_flag_a), 8'h01);
        check(8'(match_irq_b), 8'h01);
        clr_flags();
        check(8'(match_flag_a), 8'h00);
        wr(2, 8'h02);
        {os_a, os_b, clr_sel} = 6'b100110;
        pins.ext_pulses(2);
        check(8'(compare_output_pin), 8'h01);
        check(count_value, 8'h02);
        pins.ext_pulses(1);
        check(8'(compare_output_pin), 8'h00);
        check(count_value, 8'h00);
        check(8'(match_flag_b), 8'h01);
        $display("test compare output done");
        {os_a, os_b, clr_sel} = 6'b000011;
        wr(0, 8'h40);
        check(count_value, 8'h40);
        pins.clear_pulse();
        check(count_value, 8'h00);
        trg_en = 1'b1;
        foreach (edges[i]) begin
            trg_edge = edges[i];
            pins.clear_pulse();
            check(8'(counting), 8'h00);
            pins.ext_pulses(1);
            check(count_value, 8'h00);
            pins.trig_toggle();
            check(8'(counting), 8'(edges[i] != 2'b00));
            pins.ext_pulses(1);
            check(count_value, 8'(edges[i] != 2'b00));
        end
        $display("test clear pin and trigger done");
        give_verdict();
    end
endmodule
